// ### design/adc_seq_defs.vh
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

// Window modes
`define WMODE_DISABLED   3'h0
`define WMODE_ABOVE      3'h1
`define WMODE_BELOW      3'h2
`define WMODE_INSIDE     3'h3
`define WMODE_OUTSIDE    3'h4

// Result resolution select
`define RES_12BIT        2'h0
`define RES_10BIT        2'h2
`define RES_8BIT         2'h3

// Correction latency in system clock cycles
`define CORR_LATENCY     5'd13

// Status bit positions
`define STAT_RESULT_READY_FLAG      0
`define STAT_WINDOW_MATCH_FLAG      1

`endif

// ### design/adc_sequencer_window_correction.v
`timescale 1ns/100ps
`include "adc_seq_defs.vh"

module adc_sequencer_window_correction #(
  parameter N_INPUTS = 32,
  parameter RES_W    = 12
) (
  input  wire             i_sys_clk,
  input  wire             i_rst_n,
  input  wire             i_start,
  input  wire             i_free_run,
  input  wire [31:0]      i_sequence_input_select,
  input  wire [4:0]       i_positive_input_select,
  input  wire [4:0]       i_negative_input_select,
  input  wire             i_differential,
  input  wire [1:0]       i_result_resolution_select,
  input  wire [2:0]       i_window_mode_field,
  input  wire [15:0]      i_window_lower_threshold,
  input  wire [15:0]      i_window_upper_threshold,
  input  wire             i_correction_enable_bit,
  input  wire [11:0]      i_offset_correction_value,
  input  wire [11:0]      i_gain_correction_value,
  input  wire [1:0]       i_flag_clear,
  input  wire [1:0]       i_int_enable,
  input  wire             i_core_done,
  input  wire [RES_W-1:0] i_core_data,
  output reg              o_core_start,
  output reg  [4:0]       o_core_pos_sel,
  output reg  [4:0]       o_core_neg_sel,
  output reg  [15:0]      o_result,
  output reg              o_sequence_busy_bit,
  output reg  [4:0]       o_sequence_current_input,
  output reg              o_result_ready_flag,
  output reg              o_window_match_flag,
  output wire             o_irq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_CORR = 2'h2;

  reg  [1:0]  state;
  reg  [31:0] pending;
  reg         seq_mode;
  reg  [4:0]  cur_input;
  reg  [4:0]  lat_cnt;
  reg         lat_done;
  reg  [15:0] raw_hold;
  reg         win_hit;
  reg  [15:0] corr_val;

  // Lowest set bit of a mask
  function [4:0] lowest;
    input [31:0] m;
    integer k;
    begin
      lowest = 5'h00;
      for (k = 31; k >= 0; k = k - 1) begin
        if (m[k])
          lowest = k[4:0];
      end
    end
  endfunction

  // Sign-extend or zero-extend a resolution-width value to 18 bits
  function signed [17:0] norm;
    input [15:0] v;
    input [1:0]  res;
    input        diff;
    begin
      case (res)
        `RES_8BIT:  norm = diff ? {{10{v[7]}}, v[7:0]}  : {10'h000, v[7:0]};
        `RES_10BIT: norm = diff ? {{8{v[9]}}, v[9:0]}   : {8'h00, v[9:0]};
        default:    norm = diff ? {{6{v[11]}}, v[11:0]} : {6'h00, v[11:0]};
      endcase
    end
  endfunction

  // Data of this cycle's done, else the held copy
  wire        [15:0] raw_now   = i_core_done ? {{(16-RES_W){1'b0}}, i_core_data} : raw_hold;

  // Offset and gain correction, gain in 1.11 fixed point
  wire signed [13:0] diff_val  = $signed({2'b00, raw_now[11:0]})
                                 - $signed({2'b00, i_offset_correction_value});
  wire signed [27:0] prod      = diff_val * $signed({2'b00, i_gain_correction_value});
  wire signed [16:0] scaled    = prod[27:11];

  // Clamp a signed product to the 12-bit result range
  function [15:0] clamp12;
    input signed [16:0] v;
    begin
      if (v < 0)
        clamp12 = 16'h0000;
      else if (v > 17'sd4095)
        clamp12 = 16'h0fff;
      else
        clamp12 = v[15:0];
    end
  endfunction

  always @* begin
    if (!i_correction_enable_bit)
      corr_val = raw_now;
    else
      corr_val = clamp12(scaled);
  end

  wire signed [17:0] r_n  = norm(corr_val, i_result_resolution_select, i_differential);
  wire signed [17:0] lt_n = norm(i_window_lower_threshold, i_result_resolution_select,
                                 i_differential);
  wire signed [17:0] ut_n = norm(i_window_upper_threshold, i_result_resolution_select,
                                 i_differential);

  // Strict comparisons against both thresholds
  wire above_lt = r_n > lt_n;
  wire below_lt = r_n < lt_n;
  wire above_ut = r_n > ut_n;
  wire below_ut = r_n < ut_n;

  always @* begin
    case (i_window_mode_field)
      `WMODE_ABOVE:   win_hit = above_lt;
      `WMODE_BELOW:   win_hit = below_ut;
      `WMODE_INSIDE:  win_hit = above_lt && below_ut;
      `WMODE_OUTSIDE: win_hit = below_lt || above_ut;
      default:        win_hit = 1'b0;
    endcase
  end

  wire [31:0] rest     = pending & ~(32'h1 << cur_input);
  wire        more     = seq_mode && (|rest);
  wire        need_lat = i_correction_enable_bit && (!i_free_run || !lat_done);
  wire        finish   = (state == ST_CONV && i_core_done && !need_lat) ||
                         (state == ST_CORR && lat_cnt == 5'd1);

  reg  [1:0]  next_state;
  reg  [31:0] next_pending;
  reg         next_seq_mode;
  reg  [4:0]  next_cur_input;
  reg  [4:0]  next_lat_cnt;
  reg         next_lat_done;
  reg         next_core_start;
  reg  [4:0]  next_pos_sel;
  reg  [4:0]  next_neg_sel;
  reg  [15:0] next_result;
  reg         next_busy;
  reg  [4:0]  next_current_input;
  reg         next_ready_flag;
  reg         next_window_flag;

  // Sequencing decisions
  always @* begin
    next_state      = state;
    next_pending    = pending;
    next_seq_mode   = seq_mode;
    next_cur_input  = cur_input;
    next_lat_cnt    = lat_cnt;
    next_core_start = 1'b0;
    next_pos_sel    = o_core_pos_sel;
    next_neg_sel    = o_core_neg_sel;
    next_busy       = o_sequence_busy_bit;
    case (state)
      ST_IDLE: begin
        if (i_start) begin
          next_neg_sel    = i_negative_input_select;
          next_core_start = 1'b1;
          next_state      = ST_CONV;
          if (|i_sequence_input_select) begin
            next_seq_mode  = 1'b1;
            next_pending   = i_sequence_input_select;
            next_cur_input = lowest(i_sequence_input_select);
            next_pos_sel   = lowest(i_sequence_input_select);
            next_busy      = 1'b1;
          end else begin
            next_seq_mode  = 1'b0;
            next_cur_input = i_positive_input_select;
            next_pos_sel   = i_positive_input_select;
          end
        end
      end
      ST_CONV: begin
        if (i_core_done && need_lat) begin
          next_lat_cnt = `CORR_LATENCY;
          next_state   = ST_CORR;
        end
      end
      ST_CORR: begin
        next_lat_cnt = lat_cnt - 5'd1;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (finish) begin
      if (more) begin
        next_pending    = rest;
        next_cur_input  = lowest(rest);
        next_pos_sel    = lowest(rest);
        next_core_start = 1'b1;
        next_state      = ST_CONV;
      end else if (i_free_run && !seq_mode) begin
        next_core_start = 1'b1;
        next_state      = ST_CONV;
      end else begin
        next_pending = 32'h0;
        next_busy    = 1'b0;
        next_state   = ST_IDLE;
      end
    end
  end

  // Free-run remembers that the latency was paid
  always @* begin
    next_lat_done = lat_done;
    if (finish)
      next_lat_done = i_free_run;
    if (state == ST_IDLE && !i_free_run)
      next_lat_done = 1'b0;
  end

  // Result and index captured on each finish
  always @* begin
    next_result        = o_result;
    next_current_input = o_sequence_current_input;
    if (finish) begin
      next_result        = corr_val;
      next_current_input = cur_input;
    end
  end

  // Flags: set wins over clear
  always @* begin
    next_ready_flag  = o_result_ready_flag;
    next_window_flag = o_window_match_flag;
    if (finish)
      next_ready_flag = 1'b1;
    else if (i_flag_clear[`STAT_RESULT_READY_FLAG])
      next_ready_flag = 1'b0;
    if (finish && win_hit)
      next_window_flag = 1'b1;
    else if (i_flag_clear[`STAT_WINDOW_MATCH_FLAG])
      next_window_flag = 1'b0;
  end

  // Raw data kept for the latency stage
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      raw_hold <= 16'h0000;
    else if (i_core_done)
      raw_hold <= raw_now;
  end

  // Sequencer state
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= ST_IDLE;
      pending   <= 32'h0;
      seq_mode  <= 1'b0;
      cur_input <= 5'h00;
      lat_cnt   <= 5'h00;
      lat_done  <= 1'b0;
    end else begin
      state     <= next_state;
      pending   <= next_pending;
      seq_mode  <= next_seq_mode;
      cur_input <= next_cur_input;
      lat_cnt   <= next_lat_cnt;
      lat_done  <= next_lat_done;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_core_start <= 1'b0;
    else
      o_core_start <= next_core_start;
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_core_pos_sel <= 5'h00;
    else
      o_core_pos_sel <= next_pos_sel;
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_core_neg_sel <= 5'h00;
    else
      o_core_neg_sel <= next_neg_sel;
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_result <= 16'h0000;
    else
      o_result <= next_result;
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_sequence_busy_bit <= 1'b0;
    else
      o_sequence_busy_bit <= next_busy;
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_sequence_current_input <= 5'h00;
    else
      o_sequence_current_input <= next_current_input;
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_result_ready_flag <= 1'b0;
    else
      o_result_ready_flag <= next_ready_flag;
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_window_match_flag <= 1'b0;
    else
      o_window_match_flag <= next_window_flag;
  end

  assign o_irq = (o_result_ready_flag & i_int_enable[`STAT_RESULT_READY_FLAG]) |
                 (o_window_match_flag & i_int_enable[`STAT_WINDOW_MATCH_FLAG]);

endmodule

// ### verif/adc_core_model.sv
`timescale 1ns/100ps
module adc_core_model (
  input  wire        i_clk,
  input  wire        i_go,
  input  wire [4:0]  i_sel,
  input  wire [3:0]  i_dly,
  output reg         o_done,
  output reg  [11:0] o_data
);
  reg [4:0] sel;
  initial begin
    o_done = 1'b0;
    o_data = 12'h0;
  end
  always begin
    @(posedge i_clk iff i_go);
    sel = i_sel;
    repeat (i_dly) @(posedge i_clk);
    #1 o_done = 1'b1;
    o_data = 12'h100 + sel;
    @(posedge i_clk);
    #1 o_done = 1'b0;
    // Data not held past the done pulse
    o_data = ~o_data;
  end
endmodule

// ### verif/adc_seq_chk.sv
`timescale 1ns/100ps
module adc_seq_chk (
  input wire        i_sys_clk,
  input wire        i_rst_n,
  input wire        i_start,
  input wire        i_free_run,
  input wire [31:0] i_sequence_input_select,
  input wire [4:0]  i_positive_input_select,
  input wire        i_correction_enable_bit,
  input wire [1:0]  i_int_enable,
  input wire        i_core_done,
  input wire        o_core_start,
  input wire [4:0]  o_core_pos_sel,
  input wire [4:0]  o_core_neg_sel,
  input wire        o_sequence_busy_bit,
  input wire [4:0]  o_sequence_current_input,
  input wire        o_result_ready_flag,
  input wire        o_window_match_flag,
  input wire        o_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire go = i_start && !o_sequence_busy_bit && !i_free_run;
  wire last = (i_sequence_input_select >> ({1'b0, o_core_pos_sel} + 6'd1)) == 32'h0;
  wire raw = i_core_done && !i_correction_enable_bit;
  AST_GO: assert property (go && i_sequence_input_select != 32'h0 |=> o_core_start &&
    o_sequence_busy_bit && i_sequence_input_select[o_core_pos_sel]) else $error("bad start");
  AST_MASK0: assert property (go && i_sequence_input_select == 32'h0 |=> o_core_start &&
    o_core_pos_sel == $past(i_positive_input_select)) else $error("bad single input");
  AST_ORDER: assert property (o_core_start && $past(o_sequence_busy_bit) |->
    o_core_pos_sel > o_sequence_current_input) else $error("order broken");
  AST_NEG: assert property (o_sequence_busy_bit && $past(o_sequence_busy_bit) |->
    $stable(o_core_neg_sel)) else $error("negative input moved");
  AST_NEXT: assert property (o_sequence_busy_bit && raw && !last |=>
    o_core_start && o_sequence_busy_bit) else $error("next input not started");
  AST_END: assert property (o_sequence_busy_bit && raw && last |=>
    !o_sequence_busy_bit && o_result_ready_flag) else $error("busy not cleared");
  AST_RDY: assert property (raw |=> o_result_ready_flag) else $error("ready late");
  AST_LAT: assert property (i_core_done && i_correction_enable_bit && !i_free_run &&
    !o_result_ready_flag |=> !o_result_ready_flag [*8] ##1 !o_result_ready_flag [*5] ##1
    o_result_ready_flag)
    else $error("latency wrong");
  AST_IRQ: assert property (o_irq == (i_int_enable[0] && o_result_ready_flag ||
    i_int_enable[1] && o_window_match_flag)) else $error("irq wrong");
endmodule
bind adc_sequencer_window_correction adc_seq_chk u_chk (.*);

// ### verif/adc_sequencer_window_correction_tb_top.sv
`timescale 1ns/100ps
`include "adc_seq_defs.vh"
module adc_sequencer_window_correction_tb_top;
  typedef struct {logic [31:0] m; logic [4:0] p; logic [2:0] w; logic [15:0] lo;
    logic [15:0] hi; logic c; logic d; logic [1:0] s; logic f; logic [15:0] r;} row_t;
  logic clk = 0, rst_n = 0, start = 0, corr = 0, done, cs, busy, rdy, win, irq;
  logic [31:0] mask = 0;
  logic [15:0] lo = 0, hi = 0, res;
  logic [11:0] data;
  logic [4:0]  pos = 0, neg = 5'h05, ps, ns, cur;
  logic [3:0]  dly = 0;
  logic [2:0]  mode = 0;
  logic [1:0]  clr = 0, ien = 0;
  logic        frun = 0, diff = 0;
  logic [1:0]  rsel = 0;
  int fail_count = 0, samples_checked = 0, i;
  int idx[3] = '{0, 2, 31};
  row_t rows[8] = '{'{32'h0, 5'd7, `WMODE_ABOVE, 16'h0106, 16'h0, 0, 0, 2'h0, 1, 16'h0107},
    '{32'h10, 5'd7, `WMODE_BELOW, 16'h0, 16'h0104, 0, 0, 2'h0, 0, 16'h0104},
    '{32'h0, 5'd2, `WMODE_INSIDE, 16'h0101, 16'h0103, 0, 0, 2'h0, 1, 16'h0102},
    '{32'h0, 5'd5, `WMODE_OUTSIDE, 16'h0101, 16'h0103, 0, 0, 2'h0, 1, 16'h0105},
    '{32'h0, 5'd1, `WMODE_OUTSIDE, 16'h0101, 16'h0103, 0, 0, 2'h0, 0, 16'h0101},
    '{32'h0, 5'd3, `WMODE_DISABLED, 16'h0, 16'h0, 1, 0, 2'h0, 0, 16'h0080},
    '{32'h0, 5'd3, `WMODE_ABOVE, 16'h0080, 16'h0, 0, 1, `RES_8BIT, 1, 16'h0103},
    '{32'h0, 5'd5, `WMODE_BELOW, 16'h0, 16'h0f04, 0, 0, `RES_8BIT, 0, 16'h0105}};
  always #10 clk = ~clk;
  adc_sequencer_window_correction u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_start(start),
    .i_free_run(frun), .i_sequence_input_select(mask), .i_positive_input_select(pos),
    .i_negative_input_select(neg), .i_differential(diff), .i_result_resolution_select(rsel),
    .i_window_mode_field(mode), .i_window_lower_threshold(lo), .i_window_upper_threshold(hi),
    .i_correction_enable_bit(corr), .i_offset_correction_value(12'h003),
    .i_gain_correction_value(12'h400), .i_flag_clear(clr), .i_int_enable(ien),
    .i_core_done(done), .i_core_data(data), .o_core_start(cs), .o_core_pos_sel(ps),
    .o_core_neg_sel(ns), .o_result(res), .o_sequence_busy_bit(busy),
    .o_sequence_current_input(cur), .o_result_ready_flag(rdy), .o_window_match_flag(win),
    .o_irq(irq));
  adc_core_model u_core (.i_clk(clk), .i_go(cs), .i_sel(ps), .i_dly(dly), .o_done(done),
    .o_data(data));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic kick();
    clr = 2'h3;
    tick(1);
    clr = 2'h0;
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask
  task automatic wait_rdy();
    for (int k = 0; k < 40 && rdy !== 1'b1; k++) tick(1);
    check("ready", rdy, 1'b1);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    tick(3);
    rst_n = 1'b1;
    for (i = 0; i < 8; i++) begin
      {mask, pos, mode, lo, hi, corr, diff, rsel} = {rows[i].m, rows[i].p, rows[i].w,
        rows[i].lo, rows[i].hi, rows[i].c, rows[i].d, rows[i].s};
      ien = i[1:0];
      dly = i[0] ? 4'd0 : 4'd6;
      kick();
      wait_rdy();
      check("result", res, rows[i].r);
      check("window", win, rows[i].f);
      check("irq", irq, ien[0] | (ien[1] & rows[i].f));
      check("neg_sel", ns, neg);
    end
    {mask, corr, dly, diff, rsel} = {32'h8000_0005, 1'b0, 4'd3, 1'b0, 2'h0};
    kick();
    check("busy", busy, 1'b1);
    foreach (idx[j]) begin
      wait_rdy();
      check("index", cur, idx[j]);
      check("seq_result", res, 32'h100 + idx[j]);
      clr = 2'h1;
      tick(1);
      clr = 2'h0;
    end
    check("busy_end", busy, 1'b0);
    {mask, pos, corr, dly, frun} = {32'h0, 5'd3, 1'b1, 4'd0, 1'b1};
    kick();
    tick(14);
    check("rdy_lat", rdy, 1'b0);
    tick(1);
    check("rdy_first", rdy, 1'b1);
    check("fr_result", res, 16'h0080);
    clr = 2'h1;
    tick(1);
    clr = 2'h0;
    tick(1);
    check("rdy_next", rdy, 1'b1);
    frun = 1'b0;
    tick(20);
    mask = 32'h8000_0005;
    kick();
    rst_n = 1'b0;
    tick(1);
    check("busy_rst", busy, 1'b0);
    check("irq_rst", irq, 1'b0);
    rst_n = 1'b1;
    tick(10);
    check("busy_post", busy, 1'b0);
    check("rdy_post", rdy, 1'b0);
    check("cur_post", cur, 5'h00);
    print_verdict();
  end
endmodule
